// File: logic/scp_top.sv
// system control registers and shared pin routing
// assumes a synchronous 8-bit cpu i/o bus on core_clk;
// peripheral signals arrive on core_clk, pins are asynchronous
`timescale 1ns/100ps

// What this block does
// RL1: mode pin selects debug ram boot
// RL2: bank register holds dram bank number
// RL3: software uses two or four bank bits
// RL4: all registers clear on reset
// RL5: per-pin interrupt polarity select bits
// RL6: line zero takes pin or timer2
// RL7: line one takes pin or timer3
// RL8: line two takes pin or serial1
// RL9: line five takes pin or uart1 errors
// RL10: software sets routed lines edge-triggered
// RL11: two-bit field selects dma1 request
// RL12: pin 91 port bit or bus ack
// RL13: pin 5 latch strobe or dma0 ack
// RL14: uart1 modem field enables functions progressively
// RL15: pin 94 port bit or uart1 rx-ready
// RL16: pin 93 port bit or uart1 tx-ready
// RL17: three-bit code sets refresh interval
// RL18: high area to top dram bank
// RL19: dram enable maps window and pins
// RL20: two-bit field selects nmi source
// RL21: fifth register is plain storage
// RL22: decode uses low eight address bits
module scp_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// cpu i/o bus
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata_r,
	// mode strap pin
	input wire logic debug_boot_mode_pin,
	output logic debug_mode_r,
	// interrupt pins and sources
	input wire logic pin89_in,
	input wire logic pin88_in,
	input wire logic pin87_in,
	input wire logic pin86_in,
	input wire logic timer2_irq,
	input wire logic timer3_irq,
	input wire logic serial1_irq,
	input wire logic break_detect_flag,
	input wire logic receive_error_interrupt,
	// interrupt controller request lines
	output logic request_line_zero,
	output logic request_line_one,
	output logic request_line_two,
	output logic request_line_five,
	output logic request_line_fourteen,
	output logic request_line_fifteen,
	// nmi
	input wire logic pin82_in,
	output logic cpu_nmi_n_r,
	// dma routing
	input wire logic pin84_in,
	input wire logic uart0_transmit_ready,
	input wire logic uart0_receive_ready,
	input wire logic dma1_acknowledge_n,
	input wire logic dma0_acknowledge_n,
	output logic dma1_request,
	// uart1 signals
	input wire logic uart1_transmit_ready,
	input wire logic uart1_receive_ready,
	input wire logic uart1_serial_out,
	input wire logic uart1_request_to_send_n,
	input wire logic uart1_terminal_ready_n,
	input wire logic pin74_in,
	input wire logic pin75_in,
	output logic uart1_clear_to_send_n,
	output logic uart1_set_ready_n,
	// other internal sources
	input wire logic external_bus_ack_n,
	input wire logic port_latch_strobe,
	input wire logic upper_address_select_n,
	input wire logic dram_col_strobe_n,
	input wire logic dram_row_strobe_n,
	// port drive
	input wire logic [7:0] port1_out,
	input wire logic [7:0] port1_oe,
	input wire logic [2:0] port3_out,
	input wire logic [2:0] port3_oe,
	// pin 5, output only
	output logic pin5_out,
	// pins 91..94 (port1 bits 7..4)
	output logic [3:0] pin9x_out,
	output logic [3:0] pin9x_oe,
	// pins 96..98 (port1 bits 3..1)
	output logic [2:0] pin9y_out,
	output logic [2:0] pin9y_oe,
	// pins 81, 80, 77 (port3 bits 0..2)
	output logic [2:0] pin8x_out,
	output logic [2:0] pin8x_oe,
	// memory map and refresh
	output logic [7:0] dram_bank_r,
	output logic dram_area_r,
	output logic high_area_dram_r,
	output logic [7:0] wait_select_r,
	output logic refresh_req_r
);
	import scp_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] bank_r; // dram_bank_select
	logic [7:0] irq_r; // interrupt_source_routing
	logic [7:0] pin_r; // peripheral_pin_routing
	logic [7:0] mem_r; // memory_map_refresh_nmi
	logic [7:0] wait_r; // wait_and_output_select
	logic [SCP_SYNC_W-1:0] raw; // pins before the synchroniser
	logic [SCP_SYNC_W-1:0] syn; // pins after the synchroniser
	logic [7:0] ofs; // low address byte
	logic [7:0] rd_nxt; // read mux
	logic [3:0] pol_pin; // pins after polarity select
	logic [1:0] modem; // uart1 modem level
	logic [1:0] dma_sel; // dma1 request select
	scp_nmi_t nmi_sel; // nmi source select

	// ****************************************
	// pin synchroniser
	// ****************************************
	assign raw = {debug_boot_mode_pin, pin89_in, pin88_in, pin87_in, pin86_in,
		pin82_in, pin84_in, pin74_in, pin75_in};

	scp_sync u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_raw(raw),
		.pin_sync(syn)
	);

	// ****************************************
	// register bus
	// ****************************************
	// upper address byte is ignored
	assign ofs = io_addr[7:0]; // RL22

	// register writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_r <= SCP_REG_RST; // RL4
			irq_r <= SCP_REG_RST;
			pin_r <= SCP_REG_RST;
			mem_r <= SCP_REG_RST;
			wait_r <= SCP_REG_RST;
		end else if (io_wr) begin
			case (ofs)
				SCP_OFS_BANK: bank_r <= io_wdata; // RL2
				SCP_OFS_IRQ: irq_r <= io_wdata;
				SCP_OFS_PIN: pin_r <= io_wdata;
				SCP_OFS_MEM: mem_r <= io_wdata;
				SCP_OFS_WAIT: wait_r <= io_wdata; // RL21
				default: ;
			endcase
		end
	end

	// read mux; unmapped offsets answer zero
	always_comb begin
		case (ofs)
			SCP_OFS_BANK: rd_nxt = bank_r;
			SCP_OFS_IRQ: rd_nxt = irq_r;
			SCP_OFS_PIN: rd_nxt = pin_r;
			SCP_OFS_MEM: rd_nxt = mem_r;
			SCP_OFS_WAIT: rd_nxt = wait_r; // RL21
			default: rd_nxt = SCP_UNMAPPED;
		endcase
	end

	// read data held to next read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata_r <= 8'h00;
		end else if (io_rd) begin
			io_rdata_r <= rd_nxt; // RL22
		end
	end

	// ****************************************
	// mode pin
	// ****************************************
	// high: debug boot from ram
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			debug_mode_r <= 1'b0;
		end else begin
			debug_mode_r <= syn[8]; // RL1
		end
	end

	// ****************************************
	// interrupt routing
	// ****************************************
	// 1 inverts the pin level
	assign pol_pin = syn[7:4] ^ irq_r[SCP_IRQ_POL_LO +: 4]; // RL5

	// request lines
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			request_line_zero <= 1'b0;
			request_line_one <= 1'b0;
			request_line_two <= 1'b0;
			request_line_five <= 1'b0;
			request_line_fourteen <= 1'b0;
			request_line_fifteen <= 1'b0;
		end else begin
			// pin 89 or timer channel 2
			request_line_zero <= irq_r[SCP_IRQ_SEL0] ? timer2_irq : pol_pin[3]; // RL6
			// pin 88 or timer channel 3
			request_line_one <= irq_r[SCP_IRQ_SEL1] ? timer3_irq : pol_pin[2]; // RL7
			// pin 89 or serial channel 1
			request_line_two <= irq_r[SCP_IRQ_SEL2] ? serial1_irq : pol_pin[3]; // RL8
			// pin 88 or uart1 break/error
			request_line_five <= irq_r[SCP_IRQ_SEL5] ?
				(break_detect_flag | receive_error_interrupt) : pol_pin[2]; // RL9
			request_line_fourteen <= pol_pin[1]; // RL5
			request_line_fifteen <= pol_pin[0]; // RL5
		end
	end

	// ****************************************
	// nmi source
	// ****************************************
	assign nmi_sel = scp_nmi_t'(mem_r[SCP_MEM_NMI_LO +: 2]);

	// nmi low active, timer high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_nmi_n_r <= 1'b1;
		end else begin
			case (nmi_sel)
				SCP_NMI_OFF: cpu_nmi_n_r <= 1'b1; // RL20
				SCP_NMI_TMR: cpu_nmi_n_r <= ~timer3_irq; // RL20
				SCP_NMI_PIN: cpu_nmi_n_r <= syn[3]; // RL20
				SCP_NMI_BOTH: cpu_nmi_n_r <= ~timer3_irq & syn[3]; // RL20
				default: cpu_nmi_n_r <= 1'b1;
			endcase
		end
	end

	// ****************************************
	// dma request routing
	// ****************************************
	assign dma_sel = pin_r[SCP_PIN_DMA_LO +: 2];

	// 0x pin 84, 10 tx-ready, 11 rx-ready
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dma1_request <= 1'b0;
		end else begin
			case (dma_sel)
				2'b10: dma1_request <= uart0_transmit_ready; // RL11
				2'b11: dma1_request <= uart0_receive_ready; // RL11
				default: dma1_request <= syn[2]; // RL11
			endcase
		end
	end

	// ****************************************
	// uart1 modem inputs
	// ****************************************
	assign modem = pin_r[SCP_PIN_MODEM_LO +: 2];

	// unused modem inputs are forced low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			uart1_clear_to_send_n <= 1'b0;
			uart1_set_ready_n <= 1'b0;
		end else begin
			uart1_clear_to_send_n <= modem[1] ? syn[1] : 1'b0; // RL14
			uart1_set_ready_n <= (modem == 2'b11) ? syn[0] : 1'b0; // RL14
		end
	end

	// ****************************************
	// output-only pin 5
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin5_out <= 1'b0;
		end else begin
			// latch strobe or dma0 acknowledge
			pin5_out <= pin_r[SCP_PIN_LATCH] ? dma0_acknowledge_n : port_latch_strobe; // RL13
		end
	end

	// ****************************************
	// pins 91..94
	// ****************************************
	// bits 3..0 are pins 91..94
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin9x_out <= 4'h0;
			pin9x_oe <= 4'h0;
		end else begin
			// pin 91: port bit 7 or bus acknowledge
			if (pin_r[SCP_PIN_BACK]) begin
				pin9x_out[3] <= external_bus_ack_n; // RL12
				pin9x_oe[3] <= 1'b1;
			end else begin
				pin9x_out[3] <= port1_out[7]; // RL12
				pin9x_oe[3] <= port1_oe[7];
			end
			// pin 92: dma1 acknowledge only for code 01
			if (dma_sel == 2'b01) begin
				pin9x_out[2] <= dma1_acknowledge_n; // RL11
				pin9x_oe[2] <= 1'b1;
			end else begin
				pin9x_out[2] <= port1_out[6]; // RL11
				pin9x_oe[2] <= port1_oe[6];
			end
			// pin 93: port bit 5 or uart1 tx-ready
			if (pin_r[SCP_PIN_TXRDY]) begin
				pin9x_out[1] <= uart1_transmit_ready; // RL16
				pin9x_oe[1] <= 1'b1;
			end else begin
				pin9x_out[1] <= port1_out[5]; // RL16
				pin9x_oe[1] <= port1_oe[5];
			end
			// pin 94: port bit 4 or uart1 rx-ready
			if (pin_r[SCP_PIN_RXRDY]) begin
				pin9x_out[0] <= uart1_receive_ready; // RL15
				pin9x_oe[0] <= 1'b1;
			end else begin
				pin9x_out[0] <= port1_out[4]; // RL15
				pin9x_oe[0] <= port1_oe[4];
			end
		end
	end

	// ****************************************
	// pins 96..98, dram strobes
	// ****************************************
	// bits 2..0 are pins 96..98
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin9y_out <= 3'h0;
			pin9y_oe <= 3'h0;
		end else if (mem_r[SCP_MEM_DRAM]) begin
			// dram window: select, column, row strobes
			pin9y_out <= {upper_address_select_n, dram_col_strobe_n,
				dram_row_strobe_n}; // RL19
			pin9y_oe <= 3'h7;
		end else begin
			// sram window: port bits 3..1
			pin9y_out <= port1_out[3:1]; // RL19
			pin9y_oe <= port1_oe[3:1];
		end
	end

	// ****************************************
	// pins 81, 80, 77, uart1 outputs
	// ****************************************
	// bit 0 pin 81, bit 1 pin 80, bit 2 pin 77
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin8x_out <= 3'h0;
			pin8x_oe <= 3'h0;
		end else begin
			// pin 77: serial out from level 01 upward
			pin8x_out[2] <= (modem != 2'b00) ? uart1_serial_out : port3_out[2]; // RL14
			pin8x_oe[2] <= (modem != 2'b00) ? 1'b1 : port3_oe[2];
			// pin 80: request-to-send from level 10 upward
			pin8x_out[1] <= modem[1] ? uart1_request_to_send_n : port3_out[1]; // RL14
			pin8x_oe[1] <= modem[1] ? 1'b1 : port3_oe[1];
			// pin 81: terminal ready only at level 11
			pin8x_out[0] <= (modem == 2'b11) ? uart1_terminal_ready_n : port3_out[0]; // RL14
			pin8x_oe[0] <= (modem == 2'b11) ? 1'b1 : port3_oe[0];
		end
	end

	// ****************************************
	// memory map outputs
	// ****************************************
	// outputs for the bus unit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dram_bank_r <= 8'h00;
			dram_area_r <= 1'b0;
			high_area_dram_r <= 1'b0;
			wait_select_r <= 8'h00;
		end else begin
			dram_bank_r <= bank_r; // RL2
			dram_area_r <= mem_r[SCP_MEM_DRAM]; // RL19
			// high area needs dram on
			high_area_dram_r <= mem_r[SCP_MEM_DRAM] & mem_r[SCP_MEM_HIGH]; // RL18
			wait_select_r <= wait_r; // RL21
		end
	end

	// ****************************************
	// refresh timer
	// ****************************************
	// runs while dram is mapped
	scp_refresh u_refresh (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(mem_r[SCP_MEM_DRAM]),
		.rate_code(mem_r[SCP_MEM_REF_LO +: 3]),
		.refresh_req_r(refresh_req_r)
	);
endmodule

// File: logic/scp_pkg.sv
// system control pin select: shared constants
// assumes an 8-bit i/o bus decoded on bits 7:0
package scp_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] SCP_OFS_BANK = 8'h1b; // dram_bank_select
	localparam logic [7:0] SCP_OFS_IRQ = 8'h1c; // interrupt_source_routing
	localparam logic [7:0] SCP_OFS_PIN = 8'h1d; // peripheral_pin_routing
	localparam logic [7:0] SCP_OFS_MEM = 8'h1e; // memory_map_refresh_nmi
	localparam logic [7:0] SCP_OFS_WAIT = 8'h1f; // wait_and_output_select

	// reset value
	localparam logic [7:0] SCP_REG_RST = 8'h00;
	// answer for an unmapped read
	localparam logic [7:0] SCP_UNMAPPED = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int SCP_IRQ_POL_LO = 0; // 4 polarity bits, pins 89,88,87,86
	localparam int SCP_IRQ_SEL0 = 4; // line zero source
	localparam int SCP_IRQ_SEL1 = 5; // line one source
	localparam int SCP_IRQ_SEL2 = 6; // line two source
	localparam int SCP_IRQ_SEL5 = 7; // line five source
	localparam int SCP_PIN_DMA_LO = 0; // 2-bit dma1 request select
	localparam int SCP_PIN_BACK = 2; // pin 91 select
	localparam int SCP_PIN_LATCH = 3; // pin 5 select
	localparam int SCP_PIN_MODEM_LO = 4; // 2-bit uart1 modem level
	localparam int SCP_PIN_RXRDY = 6; // pin 94 select
	localparam int SCP_PIN_TXRDY = 7; // pin 93 select
	localparam int SCP_MEM_REF_LO = 0; // 3-bit refresh code
	localparam int SCP_MEM_HIGH = 4; // c0000-fffff to top dram bank
	localparam int SCP_MEM_DRAM = 5; // 80000-bffff is dram
	localparam int SCP_MEM_NMI_LO = 6; // 2-bit nmi source

	// ****************************************
	// refresh intervals in system clocks
	// ****************************************
	localparam logic [7:0] SCP_REF_0 = 8'd128;
	localparam logic [7:0] SCP_REF_1 = 8'd88;
	localparam logic [7:0] SCP_REF_2 = 8'd64;
	localparam logic [7:0] SCP_REF_3 = 8'd44;
	localparam logic [7:0] SCP_REF_4 = 8'd32;
	localparam logic [7:0] SCP_REF_5 = 8'd22;
	localparam logic [7:0] SCP_REF_6 = 8'd16;
	localparam logic [7:0] SCP_REF_7 = 8'd11;

	// synchronised pin count
	localparam int SCP_SYNC_W = 9;

	// nmi source codes
	typedef enum logic [1:0] {
		SCP_NMI_OFF = 2'b00,
		SCP_NMI_TMR = 2'b01,
		SCP_NMI_PIN = 2'b10,
		SCP_NMI_BOTH = 2'b11
	} scp_nmi_t;

endpackage

// File: logic/scp_sync.sv
// two-flop synchroniser bank for the pin inputs
// assumes inputs are asynchronous to core_clk
`timescale 1ns/100ps
module scp_sync (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// raw pins and synchronised levels
	input wire logic [scp_pkg::SCP_SYNC_W-1:0] pin_raw,
	output logic [scp_pkg::SCP_SYNC_W-1:0] pin_sync
);
	import scp_pkg::*;

	// ****************************************
	// per-bit flop pair
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < SCP_SYNC_W; gi++) begin : g_bit
			logic meta_r; // first stage, read only by the second
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_r <= 1'b0;
					pin_sync[gi] <= 1'b0;
				end else begin
					meta_r <= pin_raw[gi];
					pin_sync[gi] <= meta_r;
				end
			end
		end
	endgenerate
endmodule

// File: logic/scp_refresh.sv
// dram refresh interval timer
// assumes a rate code registered on core_clk
`timescale 1ns/100ps
module scp_refresh (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control
	input wire logic enable,
	input wire logic [2:0] rate_code,
	// one-cycle refresh request
	output logic refresh_req_r
);
	import scp_pkg::*;

	logic [7:0] count_r; // clocks left in this interval
	logic [7:0] period; // interval chosen by the code

	// ****************************************
	// code to interval lookup
	// ****************************************
	always_comb begin
		case (rate_code)
			3'd0: period = SCP_REF_0; // RL17
			3'd1: period = SCP_REF_1;
			3'd2: period = SCP_REF_2;
			3'd3: period = SCP_REF_3;
			3'd4: period = SCP_REF_4;
			3'd5: period = SCP_REF_5;
			3'd6: period = SCP_REF_6;
			default: period = SCP_REF_7;
		endcase
	end

	// down counter, pulses once per interval
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= 8'h00;
			refresh_req_r <= 1'b0;
		end else if (!enable) begin
			count_r <= 8'h00;
			refresh_req_r <= 1'b0;
		end else if (count_r <= 8'h01) begin
			count_r <= period; // RL17
			refresh_req_r <= (count_r == 8'h01);
		end else begin
			count_r <= count_r - 8'h01;
			refresh_req_r <= 1'b0;
		end
	end
endmodule

// File: verification/scp_monitor.sv
// checker for scp_top ports
// assumes a bind into scp_top
`timescale 1ns/100ps
module scp_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register bus
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata_r,
	// same-clock sources
	input wire logic timer2_irq,
	input wire logic uart0_transmit_ready,
	input wire logic uart0_receive_ready,
	input wire logic dma0_acknowledge_n,
	input wire logic upper_address_select_n,
	// routed outputs
	input wire logic request_line_zero,
	input wire logic cpu_nmi_n_r,
	input wire logic dma1_request,
	input wire logic pin5_out,
	input wire logic uart1_clear_to_send_n,
	input wire logic uart1_set_ready_n,
	input wire logic [2:0] pin9y_out,
	input wire logic [2:0] pin9y_oe,
	// register outputs
	input wire logic [7:0] dram_bank_r,
	input wire logic dram_area_r,
	input wire logic [7:0] wait_select_r,
	input wire logic refresh_req_r
);
	import scp_pkg::*;

	// ****************************************
	// register shadow
	// ****************************************
	logic [4:0][7:0] sh_r; // register copies
	logic [7:0] rd_exp_r; // expected read byte
	logic mapped; // offset hits the bank
	logic [2:0] idx; // register index within the bank
	assign mapped = (io_addr[7:0] >= SCP_OFS_BANK) && (io_addr[7:0] <= SCP_OFS_WAIT);
	assign idx = io_addr[2:0] - 3'h3;

	// follow writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_r <= '0;
		end else if (io_wr && mapped) begin
			sh_r[idx] <= io_wdata;
		end
	end

	// expected read answer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_exp_r <= '0;
		end else if (io_rd) begin
			rd_exp_r <= mapped ? sh_r[idx] : SCP_UNMAPPED;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// two quiet samples
	sequence s_quiet;
		(!io_wr) [*2];
	endsequence
	// dram window held
	sequence s_dram_held;
		sh_r[3][SCP_MEM_DRAM] [*3];
	endsequence
	// uart source held for dma1
	sequence s_dma_held;
		($stable(sh_r[2]) && sh_r[2][1]) [*3];
	endsequence

	reg_read_a: assert property (io_rd |=> io_rdata_r == rd_exp_r)
		else $error("read data wrong");
	bank_out_a: assert property (s_quiet |-> dram_bank_r == sh_r[0] && wait_select_r == sh_r[4])
		else $error("bank or wait output wrong");
	reset_clear_a: assert property ($rose(rst_n) |-> io_rdata_r == 8'h00 && dram_bank_r == 8'h00 && wait_select_r == 8'h00 && !dram_area_r && cpu_nmi_n_r)
		else $error("not clear after reset");
	nmi_off_a: assert property ((sh_r[3][7:6] == 2'h0) [*3] |-> cpu_nmi_n_r)
		else $error("nmi active while off");
	line_zero_a: assert property (sh_r[1][4] [*3] |-> request_line_zero == $past(timer2_irq))
		else $error("line zero not timer 2");
	dma_uart_a: assert property (s_dma_held |-> dma1_request == (sh_r[2][0] ? $past(uart0_receive_ready) : $past(uart0_transmit_ready)))
		else $error("dma1 request wrong");
	latch_pin_a: assert property (sh_r[2][3] [*3] |-> pin5_out == $past(dma0_acknowledge_n))
		else $error("pin 5 not dma0 ack");
	modem_off_a: assert property ((sh_r[2][5:4] == 2'h0) [*3] |-> !uart1_clear_to_send_n && !uart1_set_ready_n)
		else $error("modem inputs not low");
	refresh_gap_a: assert property (refresh_req_r |=> (!refresh_req_r) [*8])
		else $error("refresh pulses too close");
	dram_pins_a: assert property (s_dram_held |-> dram_area_r && pin9y_oe == 3'h7 && pin9y_out[2] == $past(upper_address_select_n))
		else $error("dram pins not driven");
endmodule

bind scp_top scp_monitor scp_monitor_i (.*);

// File: verification/tb_system_control_pin_select.sv
// self-checking bench for scp_top
// assumes scp_top with scp_monitor bound; 20 mhz core clock
`timescale 1ns/100ps
module tb_system_control_pin_select;
	import scp_pkg::*;
	// one table row
	typedef struct packed {
		logic [7:0] irq;
		logic [7:0] pin;
		logic [7:0] mem;
		logic [25:0] stim;
		logic [17:0] exp;
	} scp_row_t;
	scp_row_t rows [22] = '{
		{8'h0, 8'h0, 8'h0, 26'h0, 18'h80}, {8'hf, 8'h0, 8'h0, 26'h0, 18'hbf},
		{8'hf0, 8'h0, 8'h0, 26'h15f, 18'hbd}, {8'hf5, 8'h0, 8'h0, 26'ha0, 18'haa},
		{8'h0, 8'h0, 8'h0, 26'h1000a00, 18'hc0}, {8'h0, 8'h1, 8'h0, 26'h1000200, 18'h100c0},
		{8'h0, 8'h2, 8'h0, 26'h400, 18'hc0}, {8'h0, 8'h3, 8'h0, 26'h600, 18'h80},
		{8'h0, 8'hcc, 8'h0, 26'h1c000, 18'h680}, {8'h0, 8'h0, 8'h0, 26'h1c000, 18'h180},
		{8'h0, 8'h40, 8'h0, 26'h20000, 18'h880}, {8'h0, 8'h0, 8'h0, 26'h28c0000, 18'h80},
		{8'h0, 8'h10, 8'h0, 26'h28c0000, 18'h8080}, {8'h0, 8'h20, 8'h0, 26'h28c0000, 18'h29080},
		{8'h0, 8'h30, 8'h0, 26'h28c0000, 18'h2b080}, {8'h0, 8'h0, 8'h20, 26'h100000, 18'h4080},
		{8'h0, 8'h0, 8'h0, 26'h100000, 18'h80}, {8'h0, 8'h0, 8'h40, 26'h1020, 18'h0},
		{8'h0, 8'h0, 8'h80, 26'h1020, 18'h80}, {8'h0, 8'h0, 8'hc0, 26'h1000, 18'h80},
		{8'h0, 8'h0, 8'hc0, 26'h0, 18'h0}, {8'h0, 8'h0, 8'hc0, 26'h1020, 18'h0}};
	logic [7:0] ref_tab [8] = '{SCP_REF_0, SCP_REF_1, SCP_REF_2, SCP_REF_3,
		SCP_REF_4, SCP_REF_5, SCP_REF_6, SCP_REF_7};
	int fail_count = 0; // mismatches seen
	int checked = 0; // comparisons made
	// design inputs
	logic core_clk = 1'h0, rst_n = 1'h0, io_wr = 1'h0, io_rd = 1'h0, dbg = 1'h0;
	logic [15:0] io_addr = 16'h0000;
	logic [7:0] io_wdata = 8'h00;
	logic [25:0] stim = 26'h0000000; // pin and peripheral sources
	// design outputs
	logic [7:0] io_rdata_r, dram_bank_r, wait_select_r, n;
	logic debug_mode_r, request_line_zero, request_line_one, request_line_two;
	logic request_line_five, request_line_fourteen, request_line_fifteen, cpu_nmi_n_r;
	logic dma1_request, uart1_clear_to_send_n, uart1_set_ready_n, pin5_out;
	logic dram_area_r, high_area_dram_r, refresh_req_r;
	logic [3:0] pin9x_out, pin9x_oe;
	logic [2:0] pin9y_out, pin9y_oe, pin8x_out, pin8x_oe;
	logic [17:0] obs; // routed outputs in table order
	assign obs = {pin8x_out[1], pin9x_out[2], pin8x_out[2], pin9y_out[2], uart1_set_ready_n,
		uart1_clear_to_send_n, pin9x_out[0], pin9x_out[1], pin9x_out[3], pin5_out, cpu_nmi_n_r,
		dma1_request, request_line_fifteen, request_line_fourteen, request_line_five,
		request_line_two, request_line_one, request_line_zero};

	// device under test
	scp_top scp_top_i (.*, .debug_boot_mode_pin(dbg),
		.pin89_in(stim[0]), .pin88_in(stim[1]), .pin87_in(stim[2]), .pin86_in(stim[3]),
		.timer2_irq(stim[4]), .timer3_irq(stim[5]), .serial1_irq(stim[6]),
		.break_detect_flag(stim[7]), .receive_error_interrupt(stim[8]), .pin84_in(stim[9]),
		.uart0_transmit_ready(stim[10]), .uart0_receive_ready(stim[11]), .pin82_in(stim[12]),
		.dma0_acknowledge_n(stim[13]), .port_latch_strobe(stim[14]),
		.external_bus_ack_n(stim[15]), .uart1_transmit_ready(stim[16]),
		.uart1_receive_ready(stim[17]), .pin74_in(stim[18]), .pin75_in(stim[19]),
		.upper_address_select_n(stim[20]), .dram_col_strobe_n(stim[21]),
		.dram_row_strobe_n(stim[22]), .uart1_serial_out(stim[23]),
		.dma1_acknowledge_n(stim[24]), .uart1_request_to_send_n(stim[25]),
		.uart1_terminal_ready_n(1'h1), .port1_out(8'h00), .port1_oe(8'h00),
		.port3_out(3'h0), .port3_oe(3'h0));

	// 50 ns period clock
	always #25 core_clk = ~core_clk;

	// just after the next rising edge
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	// one bus write
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		tick();
		io_addr = a;
		io_wdata = d;
		io_wr = 1'h1;
		tick();
		io_wr = 1'h0;
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_row(input logic [17:0] got, input logic [17:0] exp, input int r);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t row %0d: got %h expected %h", $time, r, got, exp);
		end
	endtask
	// one bus read
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
		tick();
		io_addr = a;
		io_rd = 1'h1;
		tick();
		io_rd = 1'h0;
		chk_byte(io_rdata_r, exp, what);
	endtask
	// cycles to next refresh pulse, 255 if none
	task automatic meas(output logic [7:0] k);
		k = 8'h00;
		do begin
			tick();
			k++;
		end while (refresh_req_r !== 1'h1 && k != 8'hff);
	endtask
	task automatic test_end(input string s);
		$display("test %s finished", s);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (20) tick();
		rst_n = 1'h1;
		for (int i = 0; i < 5; i++) begin
			rd_chk({8'h00, SCP_OFS_BANK + 8'(i)}, SCP_REG_RST, "reset value");
		end
		test_end("reset");
		foreach (rows[i]) begin
			wr({8'h5a, SCP_OFS_IRQ}, rows[i].irq);
			wr({8'ha5, SCP_OFS_PIN}, rows[i].pin);
			wr({8'hff, SCP_OFS_MEM}, rows[i].mem);
			stim = rows[i].stim;
			repeat (6) tick();
			chk_row(obs, rows[i].exp, i);
		end
		stim = 26'h0000000;
		test_end("routing table");
		// upper address byte varies
		for (int i = 0; i < 5; i++) begin
			wr({8'(i * 37 + 1), SCP_OFS_BANK + 8'(i)}, 8'h0f + 8'(i * 16));
			rd_chk({8'hc3, SCP_OFS_BANK + 8'(i)}, 8'h0f + 8'(i * 16), "stored value");
		end
		chk_byte(dram_bank_r, 8'h0f, "bank output");
		chk_byte(wait_select_r, 8'h4f, "wait output");
		wr(16'h001a, 8'hff);
		rd_chk(16'h001a, SCP_UNMAPPED, "unmapped read");
		wr(16'h1b00, 8'h00);
		rd_chk(16'h001b, 8'h0f, "high byte ignored");
		test_end("registers");
		// longer intervals last
		for (int c = 7; c >= 0; c--) begin
			wr(16'h001e, 8'h20 | 8'(c));
			meas(n);
			meas(n);
			meas(n);
			chk_byte(n, ref_tab[c], "refresh interval");
		end
		wr(16'h001e, 8'h00);
		tick();
		meas(n);
		chk_byte(n, 8'hff, "refresh stopped");
		test_end("refresh");
		wr(16'h001e, 8'h30);
		repeat (3) tick();
		chk_byte({3'h0, pin9y_oe, dram_area_r, high_area_dram_r}, 8'h1f, "dram map");
		wr(16'h001e, 8'h10);
		repeat (3) tick();
		chk_byte({6'h00, dram_area_r, high_area_dram_r}, 8'h00, "sram map");
		dbg = 1'h1;
		repeat (5) tick();
		chk_byte({7'h00, debug_mode_r}, 8'h01, "debug boot");
		dbg = 1'h0;
		repeat (5) tick();
		chk_byte({7'h00, debug_mode_r}, 8'h00, "normal boot");
		wr(16'h001d, 8'hff);
		repeat (2) tick();
		chk_byte({1'h0, pin9x_oe, pin8x_oe}, 8'h5f, "pin drive");
		test_end("map and mode");
		// mid-run reset
		wr(16'h001b, 8'h0a);
		wr(16'h001e, 8'hc5);
		rst_n = 1'h0;
		repeat (3) tick();
		rst_n = 1'h1;
		for (int i = 0; i < 5; i++) begin
			rd_chk({8'h00, SCP_OFS_BANK + 8'(i)}, SCP_REG_RST, "value after reset");
		end
		chk_byte({7'h00, cpu_nmi_n_r}, 8'h01, "nmi idle");
		test_end("second reset");
		print_verdict();
	end

	// watchdog, far beyond the expected run
	initial begin
		repeat (30000) @(posedge core_clk);
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
